// ---- sar_ctrl_pkg.sv ----
`default_nettype none
package sar_ctrl_pkg;
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned ACQ_PERIOD_NS        = 250;
    localparam int unsigned ACQ_CYCLES           =
        (ACQ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_PERIOD_NS       = 1750;
    localparam int unsigned CONV_CYCLES          = CONV_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned RESULT_WIDTH         = 16;
    localparam int unsigned INT_SCLK_DIV         = 4;

    typedef enum logic [2:0] {
        ST_ACQUIRE  = 3'h0,
        ST_WAIT_EDGE = 3'h1,
        ST_CONVERT  = 3'h2,
        ST_POWERED_DOWN = 3'h3
    } conv_state_type;

    typedef struct packed {
        logic chip_select_n;
        logic read_n;
        logic serial_mode;
        logic serial_clock_source_select;
        logic ext_sclk;
    } host_if_type;
endpackage
`default_nettype wire

// ---- result_store.sv ----
`default_nettype none
module result_store #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] data_o
);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            data_o <= '0;
        end else if (load_i) begin
            data_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// ---- sar_adc_conversion_control.sv ----
// Overview of operation
// - result bus driven only with select and read low
// - external serial clock ignored while deselected
// - high reset aborts conversion, restarts acquisition, keeps stored result
// - power-down finishes current conversion, then halts
// - high start at acquisition end: wait falling edge
// - low start at acquisition end: convert immediately
// - busy high from start until result latched
// - unfinished external read at completion: discard, flag
`default_nettype none
module sar_adc_conversion_control
    import sar_ctrl_pkg::*;
#(
    parameter int unsigned WIDTH       = sar_ctrl_pkg::RESULT_WIDTH,
    parameter int unsigned ACQ_COUNT   = sar_ctrl_pkg::ACQ_CYCLES,
    parameter int unsigned CONV_COUNT  = sar_ctrl_pkg::CONV_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     device_reset_i,
    input  wire logic                     power_down_request_i,
    input  wire logic                     convert_start_n_i,
    input  wire sar_ctrl_pkg::host_if_type host_i,
    input  wire logic [WIDTH-1:0]         sar_code_i,
    output logic                          busy_o,
    output logic                          sample_hold_o,
    output logic                          powered_down_o,
    output logic [WIDTH-1:0]              parallel_data_o,
    output logic                          parallel_data_oe_n_o,
    output logic                          serial_result_out_o,
    output logic                          serial_result_oe_n_o,
    output logic                          serial_clock_out_o,
    output logic                          incomplete_read_flag_o
);
    import sar_ctrl_pkg::*;

    if (WIDTH < 2 || WIDTH > 32 || ACQ_COUNT < 1 || CONV_COUNT < 1) begin : g_bad_params
        $error("sar_adc_conversion_control: unsupported parameters");
    end

    localparam int unsigned CW = 16;
    localparam int unsigned BW = $clog2(WIDTH + 1);

    // ----------------------------------------
    // conversion sequencing
    // ----------------------------------------
    conv_state_type state_r;
    logic [CW-1:0]  cnt_r;
    logic           cnv_prev_r;
    logic           conv_done;
    logic           start_now;
    logic           cnv_fall;
    logic           acq_done;

    assign acq_done  = (cnt_r >= CW'(ACQ_COUNT - 1));
    assign cnv_fall  = cnv_prev_r && !convert_start_n_i;
    assign conv_done = (state_r == ST_CONVERT) && (cnt_r == CW'(CONV_COUNT - 1));
    // start only once acquisition has run its full time
    assign start_now = ((state_r == ST_ACQUIRE) && acq_done && !convert_start_n_i)
                    || ((state_r == ST_WAIT_EDGE) && cnv_fall);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnv_prev_r <= 1'b1;
        end else begin
            cnv_prev_r <= convert_start_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || device_reset_i) begin
            state_r <= ST_ACQUIRE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                ST_ACQUIRE: begin
                    if (power_down_request_i) begin
                        state_r <= ST_POWERED_DOWN;
                    end else if (start_now) begin
                        state_r <= ST_CONVERT;
                        cnt_r   <= '0;
                    end else if (acq_done) begin
                        state_r <= ST_WAIT_EDGE;
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
                ST_WAIT_EDGE: begin
                    if (power_down_request_i) begin
                        state_r <= ST_POWERED_DOWN;
                    end else if (start_now) begin
                        state_r <= ST_CONVERT;
                        cnt_r   <= '0;
                    end
                end
                ST_CONVERT: begin
                    // a power-down request never cuts the running conversion short
                    if (conv_done) begin
                        state_r <= power_down_request_i ? ST_POWERED_DOWN : ST_ACQUIRE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
                ST_POWERED_DOWN: begin
                    if (!power_down_request_i) begin
                        state_r <= ST_ACQUIRE;
                        cnt_r   <= '0;
                    end
                end
                default: begin
                    state_r <= ST_ACQUIRE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || device_reset_i) begin
            busy_o         <= 1'b0;
            sample_hold_o  <= 1'b0;
            powered_down_o <= 1'b0;
        end else begin
            if (start_now && !power_down_request_i) begin
                busy_o        <= 1'b1;
                sample_hold_o <= 1'b1;
            end else if (conv_done) begin
                busy_o        <= 1'b0;
                sample_hold_o <= 1'b0;
            end
            powered_down_o <= (state_r == ST_POWERED_DOWN);
        end
    end

    // ----------------------------------------
    // result register and shifter
    // ----------------------------------------
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] shift_r;
    logic [BW-1:0]    bits_left_r;
    logic             read_open_r;
    logic             sel;
    logic             ext_mode;
    logic             sclk_prev_r;
    logic             sclk_rise;
    logic [3:0]       div_r;
    logic             int_tick;
    logic             shift_en;

    result_store #(
        .WIDTH (WIDTH)
    ) u_store (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .load_i   (conv_done),
        .data_i   (sar_code_i),
        .data_o   (result)
    );

    assign sel       = !host_i.chip_select_n && !host_i.read_n;
    assign ext_mode  = host_i.serial_mode && host_i.serial_clock_source_select;
    // clock edges outside chip select never reach the shifter
    assign sclk_rise = host_i.ext_sclk && !sclk_prev_r && !host_i.chip_select_n;
    assign int_tick  = (div_r == 4'(INT_SCLK_DIV - 1));
    assign shift_en  = ext_mode ? sclk_rise : (int_tick && serial_clock_out_o && sel);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sclk_prev_r <= 1'b0;
            div_r       <= '0;
        end else begin
            sclk_prev_r <= host_i.ext_sclk;
            div_r       <= int_tick ? 4'h0 : div_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || device_reset_i) begin
            serial_clock_out_o <= 1'b0;
        end else if (int_tick) begin
            // the shared clock pin stays quiet during parallel reads
            serial_clock_out_o <= !ext_mode && host_i.serial_mode && sel
                                  && (bits_left_r != '0) && !serial_clock_out_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || device_reset_i) begin
            shift_r                <= '0;
            bits_left_r            <= '0;
            read_open_r            <= 1'b0;
            incomplete_read_flag_o <= 1'b0;
        end else begin
            incomplete_read_flag_o <= 1'b0;
            if (conv_done) begin
                // an unfinished read loses its word to the new one
                if (ext_mode && read_open_r) begin
                    incomplete_read_flag_o <= 1'b1;
                end
                shift_r     <= sar_code_i;
                bits_left_r <= BW'(WIDTH);
                read_open_r <= 1'b0;
            end else if (shift_en && bits_left_r != '0) begin
                shift_r     <= {shift_r[WIDTH-2:0], 1'b0};
                bits_left_r <= bits_left_r - BW'(1);
                read_open_r <= (bits_left_r != BW'(1));
            end
        end
    end

    // ----------------------------------------
    // output bus gating
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            parallel_data_o      <= '0;
            parallel_data_oe_n_o <= 1'b1;
            serial_result_out_o  <= 1'b0;
            serial_result_oe_n_o <= 1'b1;
        end else begin
            parallel_data_o      <= result;
            parallel_data_oe_n_o <= !(sel && !host_i.serial_mode);
            serial_result_out_o  <= shift_r[WIDTH-1];
            serial_result_oe_n_o <= !(sel && host_i.serial_mode);
        end
    end
endmodule
`default_nettype wire

// ---- sar_ctrl_assertions.sv ----
`default_nettype none
module sar_ctrl_assertions
    import sar_ctrl_pkg::*;
#(
    parameter int unsigned ACQ_COUNT  = sar_ctrl_pkg::ACQ_CYCLES,
    parameter int unsigned CONV_COUNT = sar_ctrl_pkg::CONV_CYCLES
) (
    input wire logic                      clk_i,
    input wire logic                      resetn_i,
    input wire logic                      device_reset_i,
    input wire sar_ctrl_pkg::host_if_type host_i,
    input wire logic                      busy_o,
    input wire logic                      sample_hold_o,
    input wire logic                      powered_down_o,
    input wire logic                      parallel_data_oe_n_o,
    input wire logic                      serial_result_oe_n_o,
    input wire logic                      incomplete_read_flag_o
);
    logic [8:0] busy_cnt_r;
    // counts busy cycles so a short or stretched conversion shows up
    always_ff @(posedge clk_i) begin
        busy_cnt_r <= busy_o ? busy_cnt_r + 9'h001 : 9'h000;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_busy_span: assert property ($fell(busy_o) && !$past(device_reset_i)
        |-> busy_cnt_r == CONV_COUNT) else $error("busy span off");
    a_hold_busy: assert property (busy_o |-> sample_hold_o) else $error("not held");
    a_acq_first: assert property ($rose(busy_o) |-> !$past(busy_o, ACQ_COUNT))
        else $error("start inside acquisition");
    a_abort_now: assert property (device_reset_i |=> !busy_o) else $error("no abort");
    a_powerdown_idle: assert property (powered_down_o |-> !busy_o)
        else $error("busy while powered down");
    a_oe_gated: assert property (!parallel_data_oe_n_o
        |-> !$past(host_i.chip_select_n) && !$past(host_i.read_n)) else $error("bus ungated");
    a_soe_gated: assert property (!serial_result_oe_n_o
        |-> !$past(host_i.chip_select_n) && !$past(host_i.read_n) && $past(host_i.serial_mode))
        else $error("serial bus ungated");
    a_flag_pulse: assert property (incomplete_read_flag_o |=> !incomplete_read_flag_o)
        else $error("flag too long");
    a_flag_idle: assert property (incomplete_read_flag_o |-> !busy_o) else $error("flag busy");
endmodule
bind sar_adc_conversion_control sar_ctrl_assertions #(
    .ACQ_COUNT  (ACQ_COUNT),
    .CONV_COUNT (CONV_COUNT)
) sar_ctrl_assertions_inst (
    .clk_i                  (clk_i),
    .resetn_i               (resetn_i),
    .device_reset_i         (device_reset_i),
    .host_i                 (host_i),
    .busy_o                 (busy_o),
    .sample_hold_o          (sample_hold_o),
    .powered_down_o         (powered_down_o),
    .parallel_data_oe_n_o   (parallel_data_oe_n_o),
    .serial_result_oe_n_o   (serial_result_oe_n_o),
    .incomplete_read_flag_o (incomplete_read_flag_o)
);
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model
    import sar_ctrl_pkg::*;
(
    input  wire logic                     clk_i,
    output var logic                      convert_start_n_o,
    output var sar_ctrl_pkg::host_if_type host_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial convert_start_n_o = 1'b1;
    initial host_o = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    task automatic start(input logic lvl);
        @(posedge clk_i) #1 convert_start_n_o = lvl;
    endtask
    task automatic sel(input logic cs_n, input logic rd_n, input logic ser, input logic ext);
        @(posedge clk_i) #1 host_o = '{cs_n, rd_n, ser, ext, 1'b0};
    endtask
    // serial clock rests low outside a frame
    task automatic frame(input int bits);
        repeat (bits) begin
            @(posedge clk_i) #1 host_o.ext_sclk = 1'b1;
            @(posedge clk_i) #1 host_o.ext_sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sar_ctrl_pkg::*;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        device_reset_i = 1'b0;
    logic        power_down_request_i = 1'b0;
    logic        flag_seen = 1'b0;
    logic [15:0] sar_code_i = 16'hA53C;
    logic [15:0] parallel_data_o;
    logic        convert_start_n_i, busy_o, sample_hold_o, powered_down_o;
    logic        parallel_data_oe_n_o, serial_result_out_o, serial_result_oe_n_o;
    logic        serial_clock_out_o, incomplete_read_flag_o;
    host_if_type host_i;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // short counts keep the run brief; expectations follow them
    sar_adc_conversion_control #(
        .ACQ_COUNT  (3),
        .CONV_COUNT (5)
    ) sar_adc_conversion_control_inst (
        .clk_i                  (clk_i),
        .resetn_i               (resetn_i),
        .device_reset_i         (device_reset_i),
        .power_down_request_i   (power_down_request_i),
        .convert_start_n_i      (convert_start_n_i),
        .host_i                 (host_i),
        .sar_code_i             (sar_code_i),
        .busy_o                 (busy_o),
        .sample_hold_o          (sample_hold_o),
        .powered_down_o         (powered_down_o),
        .parallel_data_o        (parallel_data_o),
        .parallel_data_oe_n_o   (parallel_data_oe_n_o),
        .serial_result_out_o    (serial_result_out_o),
        .serial_result_oe_n_o   (serial_result_oe_n_o),
        .serial_clock_out_o     (serial_clock_out_o),
        .incomplete_read_flag_o (incomplete_read_flag_o)
    );
    host_model host_model_inst (.clk_i(clk_i), .convert_start_n_o(convert_start_n_i),
        .host_o(host_i));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (incomplete_read_flag_o === 1'b1) flag_seen = 1'b1;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_busy(input logic v);
        for (int n = 0; n < 400 && busy_o !== v; n++) @(posedge clk_i) #1;
        chk("busy", 16'(v), 16'(busy_o));
    endtask
    task automatic conv_once();
        host_model_inst.start(1'b0);
        wait_busy(1'b1);
        host_model_inst.start(1'b1);
        wait_busy(1'b0);
        repeat (2) @(posedge clk_i) #1;
    endtask
    task automatic t_auto();
        @(posedge clk_i) #1 chk("early", 16'h0000, 16'(busy_o));
        wait_busy(1'b1);
        host_model_inst.sel(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge clk_i) #1 chk("oe_rd_high", 16'h0001, 16'(parallel_data_oe_n_o));
        host_model_inst.sel(1'b0, 1'b0, 1'b0, 1'b0);
        wait_busy(1'b0);
        host_model_inst.start(1'b1);
        @(posedge clk_i) #1 chk("par", 16'hA53C, parallel_data_o);
        chk("oe", 16'h0000, 16'(parallel_data_oe_n_o));
        host_model_inst.sel(1'b1, 1'b1, 1'b0, 1'b0);
        @(posedge clk_i) #1 chk("oe_off", 16'h0001, 16'(parallel_data_oe_n_o));
    endtask
    task automatic t_stop();
        host_model_inst.start(1'b0);
        wait_busy(1'b1);
        device_reset_i = 1'b1;
        @(posedge clk_i) #1 device_reset_i = 1'b0;
        @(posedge clk_i) #1 chk("abort", 16'h0000, 16'(busy_o));
        wait_busy(1'b1);
        power_down_request_i = 1'b1;
        wait_busy(1'b0);
        repeat (20) @(posedge clk_i) #1;
        chk("down_busy", 16'h0000, 16'(busy_o));
        chk("down_state", 16'h0001, 16'(powered_down_o));
        host_model_inst.start(1'b1);
        power_down_request_i = 1'b0;
    endtask
    task automatic t_serial();
        host_model_inst.sel(1'b1, 1'b1, 1'b1, 1'b1);
        conv_once();
        host_model_inst.frame(3);
        flag_seen = 1'b0;
        chk("waiting", 16'h0000, 16'(busy_o));
        chk("soe_off", 16'h0001, 16'(serial_result_oe_n_o));
        sar_code_i = 16'h52C3;
        conv_once();
        chk("flag_gated", 16'h0000, 16'(flag_seen));
        chk("par_new", 16'h52C3, parallel_data_o);
        host_model_inst.sel(1'b0, 1'b0, 1'b1, 1'b1);
        host_model_inst.frame(3);
        // three bits gone, msb first: bit 12 now leads
        @(posedge clk_i) #1 chk("sdo_bit12", 16'h0001, 16'(serial_result_out_o));
        chk("soe_on", 16'h0000, 16'(serial_result_oe_n_o));
        flag_seen = 1'b0;
        conv_once();
        chk("flag_open", 16'h0001, 16'(flag_seen));
    endtask
    task automatic t_int();
        logic last;
        int   rises;
        last  = 1'b0;
        rises = 0;
        host_model_inst.sel(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (200) begin
            @(posedge clk_i) #1;
            if (serial_clock_out_o === 1'b1 && last !== 1'b1) rises++;
            last = serial_clock_out_o;
        end
        chk("int_clocks", 16'(RESULT_WIDTH), 16'(rises));
        chk("int_soe", 16'h0000, 16'(serial_result_oe_n_o));
    endtask
    initial begin
        host_model_inst.start(1'b0);
        repeat (19) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        t_auto();
        t_stop();
        t_serial();
        t_int();
        close_out();
    end
endmodule
`default_nettype wire
